// *** core/tws_defs.svh ***
// How it works
// - First one seen on data in after select rises is the start bit.
// - Zeros before the start bit are ignored.
// - Frame is start bit, two-bit opcode, address, then data, sampled on clock rise.
// - Address and data shift most significant bit first.
// - Opcodes: 10 read, 01 write, 11 erase, 00 qualified by top address bits.
// - Address is 6, 8 or 10 bits; words are 16 bits.
// - Some variants ignore the top address bit when picking the word.
// - Read drives a dummy zero on the edge taking the last address bit.
// - Read then shifts the 16-bit word out, one bit per clock rise.
// - Continued clocks during read stream following addresses; read only.
// - Write takes 16 data bits; programming starts at the next select fall.
// - Program cycle is self-timed, 5 ms at most; commands refused while busy.
// - Write and write-all erase target cells before programming.
// - Write-all programs every word in one bulk cycle of the same time.
// - Write-enable latch clear at power on, set by enable, cleared by disable.
// - Read works whatever the write-enable latch holds.
// - Erase sets the word to all ones at select fall; shows status like write.
// - Chip erase sets all words to ones at select fall; status like write.
// - Select low cancels read, and write before the terminal clock rise.
// - After the terminal clock the program cannot be cancelled, even by clocks.
// - After a program command, data out shows ready high, busy low, while selected.
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH
`define TWS_CLK_MHZ 200
`define TWS_PROG_TIME_US 5000
`define TWS_PROG_CYCLES (`TWS_PROG_TIME_US * `TWS_CLK_MHZ)
`define TWS_ADDR_BITS 6
`define TWS_OPC_BITS 2
`define TWS_WORD_BITS 16
`define TWS_FIFO_DEPTH 16
`define TWS_OP_READ 2'h2
`define TWS_OP_WRITE 2'h1
`define TWS_OP_ERASE 2'h3
`define TWS_OP_EXT 2'h0
`define TWS_Q_WEN 2'h3
`define TWS_Q_WRITE_ALL_CMD 2'h1
`define TWS_Q_WDS 2'h0
`define TWS_Q_CHIP_ERASE_CMD 2'h2
`define TWS_ERASED 16'hFFFF
`endif

// *** core/tws_pkg.sv ***
`default_nettype none
package tws_pkg;
   typedef enum logic [5:0] {
      LK_IDLE = 6'h01,
      LK_OPC = 6'h02,
      LK_ADDR = 6'h04,
      LK_DATA = 6'h08,
      LK_READ = 6'h10,
      LK_DONE = 6'h20
   } tws_link_t;
   typedef enum logic [1:0] {
      ENG_IDLE = 2'h1,
      ENG_RUN = 2'h2
   } tws_eng_t;
   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_WRITE = 3'h1,
      CMD_WRITE_ALL_CMD = 3'h2,
      CMD_ERASE = 3'h3,
      CMD_CHIP_ERASE_CMD = 3'h4
   } tws_cmd_t;
endpackage : tws_pkg
`default_nettype wire

// *** core/tws_eeprom.sv ***
`include "tws_defs.svh"
`default_nettype none

module tws_fifo #(
   parameter int W = 28,
   parameter int D = 16
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_r [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign in_ready = cnt_r != (AW+1)'(D);
   assign out_valid = cnt_r != '0;
   assign out_data = mem_r[rp_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : tws_fifo

module tws_eeprom
   import tws_pkg::*;
#(
   parameter int ADDR_BITS = `TWS_ADDR_BITS,
   parameter bit IGNORE_MSB = 1'b0,
   parameter int PROG_CYCLES = `TWS_PROG_CYCLES
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Serial pins.
   input wire logic chip_select,
   input wire logic serial_clock_in,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_oe,
   // Status.
   output logic busy
);
   localparam int AB = ADDR_BITS;
   localparam int WB = `TWS_WORD_BITS;
   localparam int NW = 1 << AB;
   localparam int QW = 3 + AB + WB;
   localparam logic [AB-1:0] AMASK = IGNORE_MSB ? {1'b0, {(AB-1){1'b1}}} : '1;

   logic rs1_r;
   logic rst_sync_n;
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic [2:0] s3_r;
   logic [2:0] lvl_r;
   logic [2:0] prev_r;
   logic cs_lvl;
   logic sk_rise;
   logic di_lvl;
   logic cs_fall;
   tws_link_t st_r;
   tws_cmd_t cmd_r;
   logic [4:0] cnt_r;
   logic [1:0] opc_r;
   logic [AB-1:0] addr_r;
   logic [AB-1:0] addr_full;
   logic [WB-1:0] data_r;
   logic [WB-1:0] word_r;
   logic bit_r;
   logic wen_r;
   logic stat_r;
   logic do_r;
   logic oe_r;
   logic set_wen;
   logic clr_wen;
   logic start_bit;
   logic push;
   logic q_ready;
   logic q_valid;
   logic q_pop;
   logic [QW-1:0] q_out;
   tws_eng_t eng_r;
   tws_cmd_t e_cmd_r;
   logic [AB-1:0] e_addr_r;
   logic [WB-1:0] e_data_r;
   logic [31:0] timer_r;
   logic e_start;
   logic e_end;
   logic [WB-1:0] mem_r [NW];

   // Reset release through two flip-flops.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rs1_r <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rs1_r <= 1'b1;
         rst_sync_n <= rs1_r;
      end
   end

   // Pins pass three flip-flops; a level counts once the last two agree.
   for (genvar i = 0; i < 3; i++) begin : g_sync
      logic pin;
      assign pin = (i == 0) ? chip_select : (i == 1) ? serial_clock_in : serial_data_in;
      always_ff @(posedge ref_clk or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            s1_r[i] <= 1'b0;
            s2_r[i] <= 1'b0;
            s3_r[i] <= 1'b0;
            lvl_r[i] <= 1'b0;
            prev_r[i] <= 1'b0;
         end else begin
            s1_r[i] <= pin;
            s2_r[i] <= s1_r[i];
            s3_r[i] <= s2_r[i];
            if (s2_r[i] == s3_r[i]) begin
               lvl_r[i] <= s3_r[i];
            end
            prev_r[i] <= lvl_r[i];
         end
      end
   end

   assign cs_lvl = lvl_r[0];
   assign sk_rise = lvl_r[1] & ~prev_r[1];
   assign di_lvl = lvl_r[2];
   assign cs_fall = prev_r[0] & ~lvl_r[0];
   assign busy = q_valid | (eng_r == ENG_RUN);
   assign addr_full = {addr_r[AB-2:0], di_lvl};
   assign start_bit = (st_r == LK_IDLE) & cs_lvl & sk_rise & di_lvl & ~busy;
   assign set_wen = (st_r == LK_ADDR) & cs_lvl & sk_rise & (cnt_r == 5'(AB-1)) &
      (opc_r == `TWS_OP_EXT) & (addr_full[AB-1 -: 2] == `TWS_Q_WEN);
   assign clr_wen = (st_r == LK_ADDR) & cs_lvl & sk_rise & (cnt_r == 5'(AB-1)) &
      (opc_r == `TWS_OP_EXT) & (addr_full[AB-1 -: 2] == `TWS_Q_WDS);
   // Program commands commit only at the select fall after the terminal clock.
   assign push = cs_fall & (st_r == LK_DONE) & (cmd_r != CMD_NONE) & wen_r;

   // Command frame decoder.
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_r <= LK_IDLE;
         cmd_r <= CMD_NONE;
         cnt_r <= '0;
         opc_r <= '0;
         addr_r <= '0;
         data_r <= '0;
      end else if (!cs_lvl) begin
         st_r <= LK_IDLE;
         cmd_r <= CMD_NONE;
      end else if (sk_rise) begin
         case (st_r)
            LK_IDLE: begin
               if (start_bit) begin
                  st_r <= LK_OPC;
                  cnt_r <= '0;
               end
            end
            LK_OPC: begin
               opc_r <= {opc_r[0], di_lvl};
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == 5'(`TWS_OPC_BITS-1)) begin
                  st_r <= LK_ADDR;
                  cnt_r <= '0;
               end
            end
            LK_ADDR: begin
               addr_r <= addr_full;
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == 5'(AB-1)) begin
                  cnt_r <= '0;
                  case (opc_r)
                     `TWS_OP_READ: begin
                        st_r <= LK_READ;
                     end
                     `TWS_OP_WRITE: begin
                        st_r <= LK_DATA;
                        cmd_r <= CMD_WRITE;
                     end
                     `TWS_OP_ERASE: begin
                        st_r <= LK_DONE;
                        cmd_r <= CMD_ERASE;
                     end
                     default: begin
                        case (addr_full[AB-1 -: 2])
                           `TWS_Q_WRITE_ALL_CMD: begin
                              st_r <= LK_DATA;
                              cmd_r <= CMD_WRITE_ALL_CMD;
                           end
                           `TWS_Q_CHIP_ERASE_CMD: begin
                              st_r <= LK_DONE;
                              cmd_r <= CMD_CHIP_ERASE_CMD;
                           end
                           default: begin
                              st_r <= LK_DONE;
                              cmd_r <= CMD_NONE;
                           end
                        endcase
                     end
                  endcase
               end
            end
            LK_DATA: begin
               data_r <= {data_r[WB-2:0], di_lvl};
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == 5'(WB-1)) begin
                  st_r <= LK_DONE;
               end
            end
            LK_READ: begin
               st_r <= LK_READ;
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == 5'(WB-1)) begin
                  cnt_r <= '0;
                  addr_r <= addr_r + 1'b1;
               end
            end
            LK_DONE: begin
               st_r <= LK_DONE;
            end
            default: begin
               st_r <= LK_IDLE;
            end
         endcase
      end
   end

   // Read shifter with auto increment.
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         word_r <= '0;
         bit_r <= 1'b0;
      end else if (sk_rise & cs_lvl) begin
         if ((st_r == LK_ADDR) & (cnt_r == 5'(AB-1)) & (opc_r == `TWS_OP_READ)) begin
            bit_r <= 1'b0;
            word_r <= mem_r[addr_full & AMASK];
         end else if (st_r == LK_READ) begin
            bit_r <= word_r[WB-1];
            word_r <= {word_r[WB-2:0], 1'b0};
            if (cnt_r == 5'(WB-1)) begin
               word_r <= mem_r[(addr_r + 1'b1) & AMASK];
            end
         end
      end
   end

   // Engine target address, taken when a command leaves the queue.
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         e_addr_r <= '0;
      end else if (q_pop) begin
         e_addr_r <= q_out[AB+WB-1:WB];
      end
   end

   // Write-enable latch, clear from power on.
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wen_r <= 1'b0;
      end else if (set_wen) begin
         wen_r <= 1'b1;
      end else if (clr_wen) begin
         wen_r <= 1'b0;
      end
   end

   // Status display stands from a committed program until the next start bit.
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         stat_r <= 1'b0;
      end else if (push & q_ready) begin
         stat_r <= 1'b1;
      end else if (start_bit) begin
         stat_r <= 1'b0;
      end
   end

   // Registered pin drive; high impedance while deselected.
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         do_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         oe_r <= cs_lvl & ((st_r == LK_READ) | (stat_r & (st_r == LK_IDLE)));
         do_r <= (st_r == LK_READ) ? bit_r : ~busy;
      end
   end

   assign serial_data_out = do_r;
   assign serial_data_oe = oe_r;

   tws_fifo #(
      .W(QW),
      .D(`TWS_FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .rst_n(rst_sync_n),
      .in_valid(push),
      .in_ready(q_ready),
      .in_data({cmd_r, addr_r & AMASK, data_r}),
      .out_valid(q_valid),
      .out_ready(q_pop),
      .out_data(q_out)
   );

   assign q_pop = q_valid & (eng_r == ENG_IDLE);
   assign e_start = (eng_r == ENG_RUN) & (timer_r == '0);
   assign e_end = (eng_r == ENG_RUN) & (timer_r == 32'(PROG_CYCLES-1));

   // Self-timed program engine.
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         eng_r <= ENG_IDLE;
         e_cmd_r <= CMD_NONE;
         e_data_r <= '0;
         timer_r <= '0;
      end else begin
         case (eng_r)
            ENG_IDLE: begin
               if (q_pop) begin
                  eng_r <= ENG_RUN;
                  e_cmd_r <= tws_cmd_t'(q_out[QW-1 -: 3]);
                  e_data_r <= q_out[WB-1:0];
                  timer_r <= '0;
               end
            end
            ENG_RUN: begin
               timer_r <= timer_r + 32'h0000_0001;
               if (e_end) begin
                  eng_r <= ENG_IDLE;
               end
            end
            default: begin
               eng_r <= ENG_IDLE;
            end
         endcase
      end
   end

   // Word storage; erase at the start of the cycle, program at its end.
   for (genvar i = 0; i < NW; i++) begin : g_mem
      logic hit;
      logic all;
      assign all = (e_cmd_r == CMD_WRITE_ALL_CMD) | (e_cmd_r == CMD_CHIP_ERASE_CMD);
      assign hit = all | (e_addr_r == AB'(i));
      always_ff @(posedge ref_clk or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            mem_r[i] <= `TWS_ERASED;
         end else if (hit & e_start) begin
            mem_r[i] <= `TWS_ERASED;
         end else if (hit & e_end) begin
            mem_r[i] <= ((e_cmd_r == CMD_WRITE) | (e_cmd_r == CMD_WRITE_ALL_CMD)) ?
               e_data_r : `TWS_ERASED;
         end
      end
   end
endmodule : tws_eeprom

`default_nettype wire

// *** testbench/tws_host_model.sv ***
`default_nettype none
module tws_host_model (
   // Reference for the start of each frame.
   input wire logic clk,
   // Serial pins toward the device.
   output logic cs,
   output logic sk,
   output logic di,
   // Data line seen from the host.
   input wire logic do_i
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      cs = 1'b0;
      sk = 1'b0;
      di = 1'b0;
   end
   // Selects and clocks n bits out, sampling data out just before each rise.
   task automatic frame(input logic [63:0] v, input int n, output logic [63:0] got);
      got = '0;
      @(posedge clk);
      #1.2;
      cs = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         di = v[i];
         #24;
         got = {got[62:0], do_i};
         sk = 1'b1;
         #24;
         sk = 1'b0;
      end
   endtask : frame
   // Deselects while the clock is low, resetting the interface.
   task automatic drop();
      #24;
      cs = 1'b0;
      di = 1'b0;
      #120;
   endtask : drop
   // Selects without clocking, to look at the status.
   task automatic sel();
      #24;
      cs = 1'b1;
   endtask : sel
endmodule : tws_host_model
`default_nettype wire

// *** testbench/tws_eeprom_monitor.sv ***
`default_nettype none
module tws_eeprom_monitor #(
   parameter int PROG_CYCLES = 1000000
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic chip_select,
   input wire logic serial_clock_in,
   input wire logic serial_data_in,
   input wire logic serial_data_out,
   input wire logic serial_data_oe,
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 100ps;
   int busy_cnt_r;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt_r <= 0;
      end else begin
         busy_cnt_r <= busy ? busy_cnt_r + 1 : 0;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   chk_oe_off_deselect: assert property (!chip_select [*8] |-> !serial_data_oe)
      else $error("data out driven while deselected");
   chk_busy_at_fall: assert property ($rose(busy) |-> !chip_select)
      else $error("program started while selected");
   chk_prog_max: assert property (busy |-> busy_cnt_r <= PROG_CYCLES + 4)
      else $error("program cycle too long");
   chk_prog_min: assert property ($fell(busy) |-> busy_cnt_r >= PROG_CYCLES - 4)
      else $error("program cycle cut short");
   chk_busy_shown: assert property (busy && serial_data_oe |-> !serial_data_out)
      else $error("status shows ready while busy");
   chk_oe_needs_cs: assert property ($rose(serial_data_oe) |-> chip_select)
      else $error("output enabled without select");
   chk_idle_reset: assert property ($rose(rst_n) |-> !serial_data_oe && !busy)
      else $error("not idle after reset");
   chk_out_steady: assert property
      ((serial_data_oe && chip_select && !serial_clock_in && !busy) [*8]
      |-> $stable(serial_data_out))
      else $error("data out moved without a clock rise");
   chk_busy_refuses: assert property
      ((chip_select && busy && serial_data_oe) [*8] ##0 serial_data_in
      |=> serial_data_oe)
      else $error("command accepted while busy");
endmodule : tws_eeprom_monitor
bind tws_eeprom tws_eeprom_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (
   .ref_clk(ref_clk),
   .rst_n(rst_n),
   .chip_select(chip_select),
   .serial_clock_in(serial_clock_in),
   .serial_data_in(serial_data_in),
   .serial_data_out(serial_data_out),
   .serial_data_oe(serial_data_oe),
   .busy(busy)
);
`default_nettype wire

// *** testbench/tb_top.sv ***
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PROG = 400;
   logic ref_clk;
   logic rst_n;
   logic cs;
   logic sk;
   logic di;
   logic dout;
   logic oe;
   logic busy;
   logic do_line;
   int bad_count;
   int n_tests;
   logic [63:0] g;
   // An undriven data line shows the opposite of the registered data out, dout.
   assign do_line = oe ? dout : ~dout;
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   tws_eeprom #(.ADDR_BITS(6), .IGNORE_MSB(1'b0), .PROG_CYCLES(PROG)) dut (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .chip_select(cs),
      .serial_clock_in(sk),
      .serial_data_in(di),
      .serial_data_out(dout),
      .serial_data_oe(oe),
      .busy(busy)
   );
   tws_host_model host (.clk(ref_clk), .cs(cs), .sk(sk), .di(di), .do_i(do_line));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1.2;
   endtask : cyc
   task automatic send(input logic [63:0] v, input int n);
      host.frame(v, n, g);
      host.drop();
   endtask : send
   // Checks whether a program cycle started, then waits it out.
   task automatic prog(input logic exp);
      cyc(10);
      chk({15'h0, busy}, {15'h0, exp});
      for (int k = 0; k < PROG * 2 && busy !== 1'b0; k++) cyc(1);
      chk({15'h0, busy}, 16'h0000);
   endtask : prog
   task automatic rd(input logic [5:0] a, input logic [15:0] e0, input logic [15:0] e1);
      host.frame({3'b000, 1'b1, 2'b10, a, 33'h0}, 45, g);
      host.drop();
      chk({15'h0, g[32]}, 16'h0000);
      chk(g[31:16], e0);
      chk(g[15:0], e1);
   endtask : rd
   task automatic t_blank();
      rd(6'h05, 16'hFFFF, 16'hFFFF);
   endtask : t_blank
   task automatic t_locked();
      send({1'b1, 2'b01, 6'h2A, 16'h1234}, 25);
      prog(1'b0);
      rd(6'h2A, 16'hFFFF, 16'hFFFF);
   endtask : t_locked
   task automatic t_write(input logic [15:0] d);
      send({1'b1, 2'b00, 6'b110000}, 9);
      send({1'b1, 2'b01, 6'h3F, d}, 25);
      host.sel();
      cyc(10);
      chk({14'h0, oe, do_line}, 16'h0002);
      host.frame({1'b1, 2'b10, 6'h3F}, 9, g);
      prog(1'b1);
      cyc(10);
      chk({14'h0, oe, do_line}, 16'h0003);
      host.drop();
      rd(6'h3F, d, 16'hFFFF);
   endtask : t_write
   task automatic t_cancel();
      send({1'b1, 2'b01, 6'h3F, 16'h0000} >> 1, 24);
      prog(1'b0);
      rd(6'h3F, 16'h0F0F, 16'hFFFF);
   endtask : t_cancel
   task automatic t_erase();
      send({1'b1, 2'b11, 6'h3F, 4'h0}, 13);
      prog(1'b1);
      rd(6'h3F, 16'hFFFF, 16'hFFFF);
   endtask : t_erase
   task automatic t_bulk();
      send({1'b1, 2'b00, 6'b010000, 16'h1234}, 25);
      prog(1'b1);
      rd(6'h10, 16'h1234, 16'h1234);
      send({1'b1, 2'b00, 6'b100000}, 9);
      prog(1'b1);
      rd(6'h3E, 16'hFFFF, 16'hFFFF);
      send({1'b1, 2'b00, 6'b000000}, 9);
      send({1'b1, 2'b01, 6'h3F, 16'h5555}, 25);
      prog(1'b0);
      rd(6'h3F, 16'hFFFF, 16'hFFFF);
   endtask : t_bulk
   initial begin
      rst_n = 1'b0;
      bad_count = 0;
      n_tests = 0;
      repeat (2) @(posedge ref_clk);
      #1.2;
      rst_n = 1'b1;
      cyc(20);
      t_blank();
      t_locked();
      t_write(16'hA5C3);
      t_write(16'h0F0F);
      t_cancel();
      t_erase();
      t_bulk();
      conclude();
   end
   initial begin
      #400000;
      bad_count++;
      conclude();
   end
endmodule : tb_top
`default_nettype wire
